//--- rtl/asl_pkg.sv
// constants, field layouts and types for the axis step and limit logic
// How it works
// R1: step output idles high and falls at the start of every step.
// R2: step pulse stays low for half the step period, then returns high.
// R3: direction output is high while commanded position increases.
// R4: direction output is low while commanded position decreases.
// R5: cw/ccw mode pulses cw when increasing, ccw when decreasing.
// R6: unipolar servo mode gives magnitude only; direction pin shows sign.
// R7: bipolar mode gives signed 16 bit command word; zero is null.
// R8: servo axis decodes quadrature phases and index for position feedback.
// R9: drive fault input level is a bit of the axis status word.
// R10: with fault disable on, an active fault disables the axis.
// R11: after fault disable, no motion until fault clears and re-enabled.
// R12: one shared fault, home and limit set feeds both axes.
// R13: position and velocity modes stop only when moving toward the limit.
// R14: contour mode stops on either limit regardless of direction.
// R15: torque mode ignores both limits.
// R16: limit response is decelerate, stop at once, or turn axis off.
// R17: limits can be disabled; disabled limits never stop the axis.
// R18: servo homing zeroes only on index while coarse home is active.
// R19: stepper homing zeroes position on home input activation.
// R20: capture rising edge latches the current axis positions.
// R21: capture source holds pulses 100 ns minimum, retriggers below 1 kHz.
// R22: capture input level is readable as a plain digital input.
// R23: any axis error asserts that axis's driver disable output.
// R24: quadrature decodes four counts per cycle, direction by phase order.
package asl_pkg;
  localparam int unsigned AW = 8;
  localparam logic [AW-1:0] OFS_CTRL        = 8'h00;
  localparam logic [AW-1:0] OFS_STEP_PERIOD = 8'h04;
  localparam logic [AW-1:0] OFS_STEP_RUN    = 8'h08;
  localparam logic [AW-1:0] OFS_SERVO_CMD   = 8'h0C;
  localparam logic [AW-1:0] OFS_STATUS      = 8'h10;
  localparam logic [AW-1:0] OFS_ENC_POS     = 8'h14;
  localparam logic [AW-1:0] OFS_STEP_POS    = 8'h18;
  localparam logic [AW-1:0] OFS_CAP_ENC     = 8'h1C;
  localparam logic [AW-1:0] OFS_CAP_STEP    = 8'h20;

  typedef enum logic [1:0] {
    MODE_POSITION, MODE_VELOCITY, MODE_CONTOUR, MODE_TORQUE
  } asl_mode_t;
  typedef enum logic [1:0] {
    RESP_DECEL, RESP_STOP, RESP_OFF, RESP_SPARE
  } asl_resp_t;

  typedef struct packed {
    logic      home_arm_step;
    logic      home_arm_servo;
    logic      full_current_select;
    logic      unipolar;
    logic      output_mode_select;
    asl_mode_t step_mode;
    asl_mode_t servo_mode;
    asl_resp_t limit_response_config;
    logic      limit_enable;
    logic      fault_disable_on;
    logic      step_en;
    logic      servo_en;
  } asl_ctrl_t;
  localparam int unsigned CTRL_W = $bits(asl_ctrl_t);
  localparam asl_ctrl_t CTRL_RESET = '0;

  typedef struct packed {
    logic cap_flag;
    logic step_homed;
    logic servo_homed;
    logic step_lim_hit;
    logic servo_lim_hit;
    logic step_fault;
    logic servo_fault;
    logic capture_lvl;
    logic home_lvl;
    logic lim_neg_lvl;
    logic lim_pos_lvl;
    logic fault_lvl;
  } asl_status_t;
  localparam int unsigned STAT_W = $bits(asl_status_t);

  typedef struct packed {
    logic dir;
    logic run;
  } asl_run_t;
  localparam int unsigned RUN_W = $bits(asl_run_t);

  typedef struct packed {
    logic fault;
    logic home;
    logic lim_pos;
    logic lim_neg;
  } asl_axis_in_t;
  typedef struct packed {
    logic a;
    logic b;
    logic z;
  } asl_enc_t;
  localparam int unsigned RAW_W = $bits(asl_axis_in_t) + $bits(asl_enc_t) + 1;

  localparam logic [31:0] STEP_MIN_PERIOD  = 32'h0000_0002;
  localparam logic [31:0] STEP_STOP_PERIOD = 32'h0001_0000;
  localparam int unsigned STEP_DECEL_SHIFT = 3;
  localparam logic signed [15:0] SERVO_DECEL_STEP = 16'sh0040;
  localparam logic signed [15:0] SERVO_MAX_POS    = 16'sh7FFF;
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned DECEL_TICK_NS    = 1000;
  localparam int unsigned DECEL_TICK_CYC   = DECEL_TICK_NS * CLK_MHZ / 1000;
  localparam logic [15:0] DECEL_TICK_LAST  = 16'(DECEL_TICK_CYC - 1);
endpackage

//--- rtl/asl_axis_io.sv
// servo and stepper axis motion i/o with apb register slave
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
module asl_axis_io (
  input  wire logic                   ref_clk,          // system clock
  input  wire logic                   nrst,             // async reset, low
  input  wire logic                   psel,             // apb select
  input  wire logic                   penable,          // apb enable
  input  wire logic                   pwrite,           // apb write
  input  wire logic [asl_pkg::AW-1:0] paddr,            // apb byte address
  input  wire logic [31:0]            pwdata,           // apb write data
  output logic      [31:0]            prdata,           // apb read data
  output logic                        pready,           // apb ready
  output logic                        pslverr,          // apb error
  input  wire asl_pkg::asl_axis_in_t  axis_in,          // shared axis inputs
  input  wire logic                   capture_in,       // capture pin
  input  wire asl_pkg::asl_enc_t      enc_in,           // encoder phases
  output logic                        step_or_cw,       // step or cw pulse
  output logic                        dir_or_ccw,       // direction or ccw
  output logic                        step_current_half, // low = full current
  output logic                        step_drv_disable, // stepper disable
  output logic                        step_drv_enable,  // stepper enable
  output logic      [15:0]            servo_cmd_word,   // servo command
  output logic                        servo_unipolar_dir, // servo direction
  output logic                        servo_drv_disable, // servo disable
  output logic                        servo_drv_enable  // servo enable
);
  import asl_pkg::*;

  function automatic logic limit_stop(asl_mode_t m, logic mv_pos,
                                      logic mv_neg, logic lp, logic ln);
    logic r;
    unique case (m)
      MODE_POSITION, MODE_VELOCITY: r = (mv_pos & lp) | (mv_neg & ln); // R13
      MODE_CONTOUR:                 r = (mv_pos | mv_neg) & (lp | ln); // R14
      MODE_TORQUE:                  r = 1'b0; // R15
    endcase
    return r;
  endfunction

  // +1, -1 or 0 from previous and current {a,b}; up order 00,10,11,01
  function automatic logic signed [1:0] quad_delta(logic [1:0] p,
                                                  logic [1:0] c);
    logic signed [1:0] d;
    unique case ({p, c})
      4'b0010, 4'b1011, 4'b1101, 4'b0100: d = 2'sb01; // R24
      4'b0001, 4'b0111, 4'b1110, 4'b1000: d = 2'sb11; // R24
      default:                            d = 2'sb00;
    endcase
    return d;
  endfunction

  function automatic logic sticky(logic cur, logic set, logic clr);
    return set | (cur & ~clr);
  endfunction

  function automatic logic signed [15:0] toward_zero(logic signed [15:0] v);
    logic signed [15:0] r;
    if (v > SERVO_DECEL_STEP)
      r = v - SERVO_DECEL_STEP;
    else if (v < -SERVO_DECEL_STEP)
      r = v + SERVO_DECEL_STEP;
    else
      r = '0;
    return r;
  endfunction

  // input synchronisers and edge history
  logic [RAW_W-1:0] sync1;
  logic [RAW_W-1:0] sync2;
  logic [RAW_W-1:0] hist;
  wire  [RAW_W-1:0] raw = {axis_in, enc_in, capture_in};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= '0;
      sync2 <= '0;
      hist  <= '0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1; // R21
      hist  <= sync2;
    end
  end

  asl_axis_in_t s_ax;
  asl_enc_t     s_enc;
  asl_enc_t     p_enc;
  asl_axis_in_t p_ax;
  logic         s_cap;
  logic         p_cap;
  assign {s_ax, s_enc, s_cap} = sync2; // R12
  assign {p_ax, p_enc, p_cap} = hist;
  wire z_rise    = s_enc.z & ~p_enc.z;
  wire home_rise = s_ax.home & ~p_ax.home;
  wire cap_rise  = s_cap & ~p_cap; // R20

  // apb decode, one wait state
  wire acc      = psel & penable;
  wire done     = acc & pready;
  wire wr       = done & pwrite;
  wire hit_ctrl = paddr == OFS_CTRL;
  wire hit_per  = paddr == OFS_STEP_PERIOD;
  wire hit_run  = paddr == OFS_STEP_RUN;
  wire hit_cmd  = paddr == OFS_SERVO_CMD;
  wire hit_stat = paddr == OFS_STATUS;
  wire hit_enc  = paddr == OFS_ENC_POS;
  wire hit_spos = paddr == OFS_STEP_POS;
  wire hit_cenc = paddr == OFS_CAP_ENC;
  wire hit_cstp = paddr == OFS_CAP_STEP;
  wire mapped   = hit_ctrl | hit_per | hit_run | hit_cmd | hit_stat |
                  hit_enc | hit_spos | hit_cenc | hit_cstp;
  wire wr_ctrl  = wr & hit_ctrl;
  wire wr_per   = wr & hit_per;
  wire wr_run   = wr & hit_run;
  wire wr_cmd   = wr & hit_cmd;
  wire wr_stat  = wr & hit_stat;
  wire asl_ctrl_t   wctrl = asl_ctrl_t'(pwdata[CTRL_W-1:0]);
  wire asl_status_t wstat = asl_status_t'(pwdata[STAT_W-1:0]);
  wire asl_run_t    wrun  = asl_run_t'(pwdata[RUN_W-1:0]);

  // registers and state
  asl_ctrl_t          ctrl;
  asl_run_t           run;
  logic [31:0]        step_period;
  logic signed [15:0] servo_set;
  logic signed [15:0] servo_eff;
  logic               servo_decel;
  logic               step_decel;
  logic signed [31:0] enc_pos;
  logic signed [31:0] step_pos;
  logic signed [31:0] cap_enc;
  logic signed [31:0] cap_step;
  logic [31:0]        ph_cnt;
  logic [31:0]        cur_period;
  logic               step_lo;
  logic               step_dir;
  logic [15:0]        tick_cnt;
  logic               servo_fault;
  logic               step_fault;
  logic               servo_lim_hit;
  logic               step_lim_hit;
  logic               servo_homed;
  logic               step_homed;
  logic               cap_flag;
  logic [31:0]        next_rdata;

  wire tick = tick_cnt == DECEL_TICK_LAST;

  // fault and limit decisions
  wire fault_trip = ctrl.fault_disable_on & s_ax.fault; // R10
  wire resp_decel = ctrl.limit_response_config == RESP_DECEL;
  wire resp_stop  = ctrl.limit_response_config == RESP_STOP;
  wire resp_off   = ctrl.limit_response_config == RESP_OFF;
  wire servo_stop = ctrl.servo_en & ctrl.limit_enable & // R17
                    limit_stop(ctrl.servo_mode, servo_set > 16'sh0000,
                               servo_set < 16'sh0000,
                               s_ax.lim_pos, s_ax.lim_neg);
  wire step_stop  = ctrl.step_en & ctrl.limit_enable & // R17
                    limit_stop(ctrl.step_mode, run.run & run.dir,
                               run.run & ~run.dir,
                               s_ax.lim_pos, s_ax.lim_neg);
  wire signed [15:0] servo_ramp = toward_zero(servo_eff);
  wire servo_decel_done = servo_decel & tick & (servo_ramp == 16'sh0000);

  // stepper period handling
  wire [31:0] base_period = (step_period < STEP_MIN_PERIOD) ?
                            STEP_MIN_PERIOD : step_period;
  wire [31:0] grown       = cur_period + (cur_period >> STEP_DECEL_SHIFT);
  wire        at_start    = ph_cnt == '0;
  wire        step_done   = step_decel & at_start &
                            (grown >= STEP_STOP_PERIOD);
  wire        step_go     = ctrl.step_en & run.run & ~step_done &
                            ~(step_stop & ~resp_decel); // R11
  wire        start_step  = at_start & step_go;
  wire [31:0] next_period = step_decel ? grown : base_period;
  wire [31:0] half_point  = cur_period >> 1;
  wire        cycle_end   = ph_cnt == cur_period - 32'h0000_0001;
  wire signed [31:0] step_inc = (run.dir ? 32'sd1 : -32'sd1);

  wire servo_lim_set = (servo_stop & ~resp_decel) | servo_decel_done;
  wire step_lim_set  = (step_stop & ~resp_decel) | step_done;

  // control: software writes, hardware disables
  asl_ctrl_t next_ctrl;
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl = wctrl;
      // no enable while a fault holds
      if (fault_trip) begin
        next_ctrl.servo_en = ctrl.servo_en; // R11
        next_ctrl.step_en  = ctrl.step_en; // R11
      end
    end
    if (fault_trip) begin
      next_ctrl.servo_en = 1'b0; // R10
      next_ctrl.step_en  = 1'b0; // R10
    end
    if (servo_stop & resp_off)
      next_ctrl.servo_en = 1'b0; // R16
    if (step_stop & resp_off)
      next_ctrl.step_en = 1'b0; // R16
    if (z_rise & s_ax.home & ctrl.home_arm_servo)
      next_ctrl.home_arm_servo = 1'b0;
    if (home_rise & ctrl.home_arm_step)
      next_ctrl.home_arm_step = 1'b0;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      if (acc & ~pready) begin
        prdata <= mapped ? next_rdata : '0;
      end
    end
  end

  asl_status_t stat;
  assign stat = '{cap_flag: cap_flag, step_homed: step_homed,
                  servo_homed: servo_homed, step_lim_hit: step_lim_hit,
                  servo_lim_hit: servo_lim_hit, step_fault: step_fault,
                  servo_fault: servo_fault, capture_lvl: s_cap, // R22
                  home_lvl: s_ax.home, lim_neg_lvl: s_ax.lim_neg,
                  lim_pos_lvl: s_ax.lim_pos, fault_lvl: s_ax.fault}; // R9

  assign next_rdata =
      hit_ctrl ? {{(32-CTRL_W){1'b0}}, ctrl} :
      hit_per  ? step_period :
      hit_run  ? {{(32-RUN_W){1'b0}}, run} :
      hit_cmd  ? {{16{servo_set[15]}}, servo_set} :
      hit_stat ? {{(32-STAT_W){1'b0}}, stat} :
      hit_enc  ? enc_pos :
      hit_spos ? step_pos :
      hit_cenc ? cap_enc :
      cap_step;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl        <= CTRL_RESET;
      step_period <= '0;
      tick_cnt    <= '0;
    end else begin
      ctrl     <= next_ctrl;
      tick_cnt <= tick ? '0 : tick_cnt + 16'h0001;
      if (wr_per)
        step_period <= pwdata;
    end
  end

  // sticky status flags, set beats clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      servo_fault   <= 1'b0;
      step_fault    <= 1'b0;
      servo_lim_hit <= 1'b0;
      step_lim_hit  <= 1'b0;
      servo_homed   <= 1'b0;
      step_homed    <= 1'b0;
      cap_flag      <= 1'b0;
    end else begin
      servo_fault   <= sticky(servo_fault, fault_trip & ctrl.servo_en,
                              wr_stat & wstat.servo_fault);
      step_fault    <= sticky(step_fault, fault_trip & ctrl.step_en,
                              wr_stat & wstat.step_fault);
      servo_lim_hit <= sticky(servo_lim_hit, servo_lim_set,
                              wr_stat & wstat.servo_lim_hit);
      step_lim_hit  <= sticky(step_lim_hit, step_lim_set,
                              wr_stat & wstat.step_lim_hit);
      servo_homed   <= sticky(servo_homed,
                              z_rise & s_ax.home & ctrl.home_arm_servo,
                              wr_stat & wstat.servo_homed);
      step_homed    <= sticky(step_homed, home_rise & ctrl.home_arm_step,
                              wr_stat & wstat.step_homed);
      cap_flag      <= sticky(cap_flag, cap_rise,
                              wr_stat & wstat.cap_flag);
    end
  end

  // servo command path
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      servo_set   <= '0;
      servo_eff   <= '0;
      servo_decel <= 1'b0;
    end else begin
      if (wr_cmd)
        servo_set <= pwdata[15:0];
      if (!ctrl.servo_en) begin
        servo_eff   <= '0; // R11
        servo_decel <= 1'b0;
      end else if (servo_stop & resp_stop) begin
        servo_eff <= '0; // R16
        servo_set <= '0;
      end else if (servo_decel | (servo_stop & resp_decel)) begin
        servo_decel <= ~servo_decel_done; // R16
        if (tick)
          servo_eff <= servo_ramp;
        if (servo_decel_done)
          servo_set <= '0;
      end else begin
        servo_eff <= servo_set;
      end
    end
  end

  wire servo_neg = servo_eff[15];
  wire signed [15:0] servo_mag = servo_eff == 16'sh8000 ? SERVO_MAX_POS :
                                 servo_neg ? -servo_eff : servo_eff;

  // encoder feedback, homing and capture
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      enc_pos  <= '0;
      cap_enc  <= '0;
      cap_step <= '0;
    end else begin
      if (z_rise & s_ax.home & ctrl.home_arm_servo)
        enc_pos <= '0; // R18
      else
        enc_pos <= enc_pos + 32'(quad_delta({p_enc.a, p_enc.b},
                                            {s_enc.a, s_enc.b})); // R8
      if (cap_rise) begin
        cap_enc  <= enc_pos; // R20
        cap_step <= step_pos; // R20
      end
    end
  end

  // stepper pulse generator
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      run        <= '0;
      step_decel <= 1'b0;
      ph_cnt     <= '0;
      cur_period <= STEP_MIN_PERIOD;
      step_lo    <= 1'b0;
      step_dir   <= 1'b1;
      step_pos   <= '0;
    end else begin
      if (wr_run)
        run <= wrun;
      if ((step_stop & resp_stop) | step_done)
        run.run <= 1'b0; // R16
      if (!ctrl.step_en | step_done | (wr_run & ~wrun.run))
        step_decel <= 1'b0;
      else if (step_stop & resp_decel)
        step_decel <= 1'b1; // R16
      if (start_step) begin
        step_lo    <= 1'b1; // R1
        step_dir   <= run.dir;
        cur_period <= next_period;
        ph_cnt     <= 32'h0000_0001;
      end else if (!at_start) begin
        if (ph_cnt == half_point)
          step_lo <= 1'b0; // R2
        ph_cnt <= cycle_end ? '0 : ph_cnt + 32'h0000_0001;
      end else begin
        step_dir <= run.dir;
      end
      if (home_rise & ctrl.home_arm_step)
        step_pos <= '0; // R19
      else if (start_step)
        step_pos <= step_pos + step_inc;
    end
  end

  // registered pin outputs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      step_or_cw         <= 1'b1;
      dir_or_ccw         <= 1'b1;
      step_current_half  <= 1'b1;
      step_drv_disable   <= 1'b1;
      step_drv_enable    <= 1'b0;
      servo_cmd_word     <= '0;
      servo_unipolar_dir <= 1'b1;
      servo_drv_disable  <= 1'b1;
      servo_drv_enable   <= 1'b0;
    end else begin
      if (ctrl.output_mode_select) begin
        step_or_cw <= ~(step_lo & step_dir); // R5
        dir_or_ccw <= ~(step_lo & ~step_dir); // R5
      end else begin
        step_or_cw <= ~step_lo; // R1
        dir_or_ccw <= step_dir; // R3 R4
      end
      step_current_half  <= ~ctrl.full_current_select;
      servo_cmd_word     <= ctrl.unipolar ? servo_mag : servo_eff; // R6 R7
      servo_unipolar_dir <= ~servo_neg; // R6
      step_drv_disable   <= ~ctrl.step_en | s_ax.fault | step_lim_hit; // R23
      step_drv_enable    <= ctrl.step_en & ~s_ax.fault & ~step_lim_hit;
      servo_drv_disable  <= ~ctrl.servo_en | s_ax.fault |
                            servo_lim_hit; // R23
      servo_drv_enable   <= ctrl.servo_en & ~s_ax.fault & ~servo_lim_hit;
    end
  end
endmodule

//--- sim/asl_chk_properties.sv
// port assertions for the axis step and limit logic
`timescale 1ns/1ns
module asl_chk (
  input wire logic                  ref_clk,          // clock
  input wire logic                  nrst,             // reset, low
  input wire logic                  psel,             // apb select
  input wire logic                  penable,          // apb enable
  input wire logic                  pready,           // apb ready
  input wire logic                  pslverr,          // apb error
  input wire asl_pkg::asl_axis_in_t axis_in,          // switches
  input wire logic                  step_or_cw,       // step pin
  input wire logic                  dir_or_ccw,       // dir pin
  input wire logic                  step_drv_disable, // step off
  input wire logic                  step_drv_enable,  // step on
  input wire logic                  servo_drv_disable // servo off
);
  import asl_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_wait; $rose(penable) && psel |-> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait) else $error("ready timing");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("lone error");
  property p_rst;
    $rose(nrst) |-> step_or_cw && dir_or_ccw && step_drv_disable
      && servo_drv_disable;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset levels");
  property p_cpl; step_drv_enable != step_drv_disable; endproperty
  a_cpl: assert property (p_cpl) else $error("driver pins agree");
  property p_flt;
    axis_in.fault [*5] |-> servo_drv_disable && step_drv_disable;
  endproperty
  a_flt: assert property (p_flt) else $error("fault kept on");
  property p_dir;
    !step_or_cw && !$past(step_or_cw) |-> $stable(dir_or_ccw);
  endproperty
  a_dir: assert property (p_dir) else $error("dir moved");
  property p_one; !($fell(step_or_cw) && $fell(dir_or_ccw)); endproperty
  a_one: assert property (p_one) else $error("both lines pulse");
  c_step: cover property ($fell(step_or_cw));
  c_err: cover property (pslverr);
  c_off: cover property ($rose(servo_drv_disable));
endmodule
bind asl_axis_io asl_chk asl_chk_inst (.ref_clk, .nrst, .psel, .penable,
  .pready, .pslverr, .axis_in, .step_or_cw, .dir_or_ccw, .step_drv_disable,
  .step_drv_enable, .servo_drv_disable);

//--- sim/asl_drv.sv
// stepper driver, switch and encoder source model
`timescale 1ns/1ns
module asl_drv (
  input  wire logic            ref_clk,    // clock
  input  wire logic            step_or_cw, // step or cw
  input  wire logic            dir_or_ccw, // dir or ccw
  output asl_pkg::asl_axis_in_t axis_in,   // switches
  output asl_pkg::asl_enc_t     enc_in,    // encoder
  output logic                 capture_in  // capture pin
);
  import asl_pkg::*;
  int steps = 0, ccws = 0, low_len = 0, high_len = 0, run = 0, pos = 0;
  logic l_stp = 1'b1;
  logic l_ccw = 1'b1;
  initial {axis_in, enc_in, capture_in} = '0;
  // pulse lengths as the driver sees them
  always @(posedge ref_clk) begin
    run++;
    if (l_stp && !step_or_cw) begin
      steps++;
      high_len = run;
      run = 0;
    end
    if (!l_stp && step_or_cw) begin
      low_len = run;
      run = 0;
    end
    if (l_ccw && !dir_or_ccw) ccws++;
    {l_stp, l_ccw} = {step_or_cw, dir_or_ccw};
  end
  task automatic set_in(input asl_axis_in_t v);
    @(posedge ref_clk);
    axis_in <= v;
  endtask
  task automatic enc_move(input int n, input logic up);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge ref_clk);
      pos = up ? pos + 1 : pos - 1;
      enc_in <= {pos[1] ^ pos[0], pos[1], ~|pos[1:0]};
    end
  endtask
  // caller holds it over 100 ns
  task automatic cap_set(input logic v);
    @(posedge ref_clk);
    capture_in <= v;
  endtask
endmodule

//--- sim/test_axis_step_and_limit_io.sv
// self-checking bench for the axis step and limit logic
`timescale 1ns/1ns
module test_axis_step_and_limit_io;
  import asl_pkg::*;
  logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, err_seen;
  logic step_or_cw, dir_or_ccw, step_current_half, servo_unipolar_dir;
  logic step_drv_disable, step_drv_enable, servo_drv_disable;
  logic servo_drv_enable, capture_in;
  logic [AW-1:0] paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic [15:0]   servo_cmd_word;
  asl_axis_in_t  axis_in;
  asl_enc_t      enc_in;
  int errors = 0;
  int cmp_count = 0;
  asl_axis_io asl_axis_io_inst (.ref_clk, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .axis_in, .capture_in,
    .enc_in, .step_or_cw, .dir_or_ccw, .step_current_half, .step_drv_disable,
    .step_drv_enable, .servo_cmd_word, .servo_unipolar_dir,
    .servo_drv_disable, .servo_drv_enable);
  asl_drv asl_drv_inst (.ref_clk, .step_or_cw, .dir_or_ccw, .axis_in,
    .enc_in, .capture_in);
  task automatic give_verdict();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s %h %h", $time, msg, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [AW-1:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    {err_seen, rd} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
  endtask
  task automatic t_reset();
    chk(step_or_cw, 1'b1, "step idle");
    apb(1'b0, 8'hE4, 32'h0);
    chk({err_seen, rd[30:0]}, 32'h8000_0000, "unmapped");
  endtask
  task automatic t_step(input logic cw, input logic dir);
    int s0, c0;
    logic [31:0] p0;
    apb(1'b1, OFS_CTRL, {21'h0, cw, 10'h002});
    apb(1'b1, OFS_STEP_PERIOD, 32'h8);
    apb(1'b0, OFS_STEP_POS, 32'h0);
    {p0, s0, c0} = {rd, asl_drv_inst.steps, asl_drv_inst.ccws};
    apb(1'b1, OFS_STEP_RUN, {30'h0, dir, 1'b1});
    repeat (83) @(posedge ref_clk);
    if (!cw) chk(dir_or_ccw, dir, "dir level");
    apb(1'b1, OFS_STEP_RUN, 32'h0);
    repeat (10) @(posedge ref_clk);
    s0 = asl_drv_inst.steps - s0;
    c0 = asl_drv_inst.ccws - c0;
    if (cw) chk(dir ? c0 : s0, 32'h0, "quiet line");
    else chk({asl_drv_inst.low_len[15:0], asl_drv_inst.high_len[15:0]},
      32'h40004, "duty");
    s0 = (cw && !dir) ? c0 : s0;
    chk(step_or_cw && s0 > 8, 1'b1, "pulses");
    apb(1'b0, OFS_STEP_POS, 32'h0);
    chk(rd - p0, dir ? s0 : -s0, "position");
  endtask
  task automatic t_limits();
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, OFS_CTRL,
        {22'h0, (i == 4) ? 2'h2 : 2'(i), 4'h1, i < 4, 3'h2});
      asl_drv_inst.set_in(4'h1);
      apb(1'b1, OFS_STEP_RUN, 32'h3);
      repeat (40) @(posedge ref_clk);
      apb(1'b0, OFS_STEP_RUN, 32'h0);
      chk(rd, {31'h1, i != 2}, "far limit");
      asl_drv_inst.set_in(4'h3);
      repeat (40) @(posedge ref_clk);
      apb(1'b0, OFS_STEP_RUN, 32'h0);
      chk(rd, {31'h1, i >= 3}, "near limit");
      chk(step_drv_disable, i < 3, "limit off");
      asl_drv_inst.set_in(4'h0);
      apb(1'b1, OFS_STEP_RUN, 32'h0);
      apb(1'b1, OFS_STATUS, 32'h180);
    end
  endtask
  task automatic t_fault();
    apb(1'b1, OFS_CTRL, 32'h7);
    asl_drv_inst.set_in(4'h8);
    repeat (4) @(posedge ref_clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'h61, 32'h61, "fault bits");
    chk({servo_drv_enable, step_drv_enable}, 2'b00, "trip");
    apb(1'b1, OFS_CTRL, 32'h7);
    asl_drv_inst.set_in(4'h0);
    repeat (10) @(posedge ref_clk);
    chk(servo_drv_enable, 1'b0, "held off");
    apb(1'b1, OFS_STATUS, 32'h60);
    apb(1'b1, OFS_CTRL, 32'h7);
    repeat (4) @(posedge ref_clk);
    chk(servo_drv_enable, 1'b1, "enabled again");
  endtask
  task automatic t_servo();
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_SERVO_CMD, 32'hFFFF_FFFB);
    repeat (4) @(posedge ref_clk);
    chk(servo_cmd_word, 16'hFFFB, "bipolar");
    apb(1'b1, OFS_CTRL, 32'h801);
    repeat (4) @(posedge ref_clk);
    chk({servo_unipolar_dir, servo_cmd_word}, 17'h5, "unipolar");
  endtask
  task automatic t_enc();
    asl_drv_inst.enc_move(12, 1'b1);
    asl_drv_inst.enc_move(5, 1'b0);
    asl_drv_inst.cap_set(1'b1);
    repeat (20) @(posedge ref_clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'h810, 32'h810, "capture");
    asl_drv_inst.cap_set(1'b0);
    asl_drv_inst.enc_move(3, 1'b1);
    apb(1'b0, OFS_CAP_ENC, 32'h0);
    chk(rd, 32'h7, "latched");
    apb(1'b1, OFS_CTRL, 32'h6000);
    asl_drv_inst.set_in(4'h4);
    asl_drv_inst.enc_move(3, 1'b1);
    apb(1'b0, OFS_STEP_POS, 32'h0);
    chk(rd, 32'h0, "home");
    apb(1'b0, OFS_ENC_POS, 32'h0);
    chk(rd, 32'h1, "index");
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    errors++;
    give_verdict();
  end
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata} <= '0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    for (int k = 0; k < 4; k++) t_step(k[1], k[0]);
    t_limits();
    t_fault();
    t_servo();
    t_enc();
    give_verdict();
  end
endmodule
